// ### rtl/csr_defs.svh
// Offsets, field positions, reset values and codes of the channel setting bank.
// Assumes inclusion by bare name from any file that decodes these registers.
`ifndef CSR_DEFS_SVH
`define CSR_DEFS_SVH
// Register byte offsets.
`define CSR_CH1_OFF 8'h04
`define CSR_CH2_OFF 8'h05
`define CSR_DRV_OFF 8'h06
`define CSR_STAT_OFF 8'h10
// Field positions inside a channel setting register.
`define CSR_PD_BIT 7
`define CSR_GAIN_HI 6
`define CSR_GAIN_LO 4
`define CSR_SEL_HI 3
`define CSR_SEL_LO 0
// Reset values; every field defaults to zero.
`define CSR_CH_RST 8'h00
`define CSR_DRV_RST 8'h00
// Gain codes.
`define CSR_GAIN_6 3'h0
`define CSR_GAIN_1 3'h1
`define CSR_GAIN_2 3'h2
`define CSR_GAIN_3 3'h3
`define CSR_GAIN_4 3'h4
`define CSR_GAIN_8 3'h5
`define CSR_GAIN_12 3'h6
// Input selection codes; the first reserved code bounds the legal set.
`define CSR_SEL_SHORTED 4'h1
`define CSR_SEL_SUPPLY 4'h3
`define CSR_SEL_RESERVED 4'ha
`define CSR_ROUTES 10
// Chop frequency codes.
`define CSR_CHOP_16 2'h0
`define CSR_CHOP_RSV 2'h1
`define CSR_CHOP_2 2'h2
`define CSR_CHOP_4 2'h3
`endif

// ### rtl/csr_pkg.sv
// Types shared by the channel setting bank and its decoders.
// Assumes nothing beyond a SystemVerilog compiler.
package csr_pkg;
  // One channel setting register.
  typedef struct packed {
    logic power_down;
    logic [2:0] gain_code;
    logic [3:0] input_select;
  } csr_chan_cfg_t;
  // The drive sense selection register.
  typedef struct packed {
    logic [1:0] chop_code;
    logic drive_buffer_on;
    logic drive_leadoff_sense_en;
    logic drive_from_chan_two_neg;
    logic drive_from_chan_two_pos;
    logic drive_from_chan_one_neg;
    logic drive_from_chan_one_pos;
  } csr_drive_cfg_t;
endpackage

// ### rtl/csr_chan_decode.sv
// Per-channel decoder: gain factor, one-hot input route and bad-code flag.
// Assumes the configuration input comes from a register on the same clock.
`include "csr_defs.svh"
module csr_chan_decode
  import csr_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire csr_chan_cfg_t cfg,
  output logic [3:0] gain_value,
  output logic [`CSR_ROUTES-1:0] route,
  output logic cfg_bad
);
  // Gain factor looked up from the code.
  logic [3:0] next_gain_value;
  // A code is legal when the select is below the reserved code and gain is defined.
  wire sel_ok = cfg.input_select < `CSR_SEL_RESERVED;
  wire gain_ok = cfg.gain_code != 3'h7;
  // The gain code maps to the amplifier factor.
  always_comb begin
    case (cfg.gain_code)
      `CSR_GAIN_6: next_gain_value = 4'h6;
      `CSR_GAIN_1: next_gain_value = 4'h1;
      `CSR_GAIN_2: next_gain_value = 4'h2;
      `CSR_GAIN_3: next_gain_value = 4'h3;
      `CSR_GAIN_4: next_gain_value = 4'h4;
      `CSR_GAIN_8: next_gain_value = 4'h8;
      `CSR_GAIN_12: next_gain_value = 4'hc;
      default: next_gain_value = 4'h0;
    endcase
  end
  // Outputs are registered; a reserved select drives no route at all.
  always_ff @(posedge clock) begin
    if (srst) begin
      gain_value <= 4'h0;
      route <= '0;
      cfg_bad <= 1'b0;
    end else begin
      gain_value <= next_gain_value;
      route <= sel_ok ? (`CSR_ROUTES'(1) << cfg.input_select) : '0;
      cfg_bad <= !(sel_ok && gain_ok);
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  a_gain_eight_map: assert property (cfg.gain_code == `CSR_GAIN_8 |=> gain_value == 4'h8)
    else $error("gain code for eight not decoded");
  a_reserved_no_route: assert property (cfg.input_select >= `CSR_SEL_RESERVED |=> route == '0)
    else $error("reserved input code drove a route");
  a_route_one_hot: assert property (sel_ok |=> $onehot(route))
    else $error("legal input code gave no single route");
endmodule // csr_chan_decode

// ### rtl/csr_drive_decode.sv
// Drive sense decoder: chop divider and the input taps feeding the drive.
// Assumes the configuration input comes from a register on the same clock.
`include "csr_defs.svh"
module csr_drive_decode
  import csr_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire csr_drive_cfg_t cfg,
  output logic [4:0] chop_divide,
  output logic [3:0] drive_taps,
  output logic chop_bad
);
  // Divider of the modulator clock chosen by the chop code.
  logic [4:0] next_chop_divide;
  always_comb begin
    case (cfg.chop_code)
      `CSR_CHOP_16: next_chop_divide = 5'h10;
      `CSR_CHOP_2: next_chop_divide = 5'h02;
      `CSR_CHOP_4: next_chop_divide = 5'h04;
      default: next_chop_divide = 5'h00;
    endcase
  end
  // Each set select bit connects its input; the taps are held off while the buffer is off.
  always_ff @(posedge clock) begin
    if (srst) begin
      chop_divide <= 5'h00;
      drive_taps <= 4'h0;
      chop_bad <= 1'b0;
    end else begin
      chop_divide <= next_chop_divide;
      drive_taps <= cfg.drive_buffer_on ? cfg[3:0] : 4'h0;
      chop_bad <= cfg.chop_code == `CSR_CHOP_RSV;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  a_chop_reserved_zero: assert property (cfg.chop_code == `CSR_CHOP_RSV |=> chop_divide == 5'h00 && chop_bad)
    else $error("reserved chop code not flagged");
  a_buffer_off_taps: assert property (!cfg.drive_buffer_on |=> drive_taps == 4'h0)
    else $error("drive taps live while buffer is off");
endmodule // csr_drive_decode

// ### rtl/channel_settings_regs.sv
// Channel setting register bank: two channel setting registers, the drive
// sense selection register and a status register, with their decoders.
// Assumes a host master on a plain strobe port in the same clock domain.
//
// Contract
// - Channel one bit 7 powers channel down.
// - Channel one bits 6:4 hold gain code.
// - Channel one bits 3:0 select input source.
// - Drive-node codes, third pair, reserved 1010.
// - Channel two register sits at 05h.
// - Channel two bit 7 powers it down.
// - Channel two gain uses channel one encoding.
// - Channel two input uses same code set.
// - Drive sense register sits at 06h.
// - Drive register: chop, buffer, leadoff, four taps.
// - Chop code selects divide 16, 2, 4.
// - Buffer bit enables; tap bit connects input.
//
// The implementer's own choice: the plain strobed port.
`include "csr_defs.svh"
module channel_settings_regs
  import csr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // System clock at 200 MHz.
  input wire logic clock,
  // Synchronous active-high reset.
  input wire logic srst,
  // Register byte address.
  input wire logic [ADDR_W-1:0] addr,
  // Write data.
  input wire logic [7:0] wdata,
  // One-cycle write strobe.
  input wire logic wr_strobe,
  // One-cycle read strobe.
  input wire logic rd_strobe,
  // Read data, valid the cycle after the read strobe.
  output logic [7:0] rdata,
  // Channel one setting register contents.
  output csr_chan_cfg_t chan_one_cfg,
  // Channel two setting register contents.
  output csr_chan_cfg_t chan_two_cfg,
  // Drive sense selection register contents.
  output csr_drive_cfg_t drive_cfg,
  // Decoded gain factors.
  output logic [3:0] chan_one_gain,
  output logic [3:0] chan_two_gain,
  // One-hot input routes, zero for a reserved code.
  output logic [`CSR_ROUTES-1:0] chan_one_route,
  output logic [`CSR_ROUTES-1:0] chan_two_route,
  // Modulator clock divider for chopping, zero when reserved.
  output logic [4:0] chop_divide,
  // Inputs connected to the drive derivation.
  output logic [3:0] drive_taps
);

  // The status offset must fit the address.
  if (ADDR_W < 5) begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end

  // Channel registers live in an array so both share one write path.
  csr_chan_cfg_t chan_cfg [2];
  // Flags from the decoders that report undefined codes.
  logic [1:0] chan_bad;
  logic chop_bad;

  // Gain and route outputs of both decoders, gathered per channel.
  logic [3:0] gain_arr [2];
  logic [`CSR_ROUTES-1:0] route_arr [2];

  // Address decode of each register.
  wire hit_ch1 = addr == ADDR_W'(`CSR_CH1_OFF);
  wire hit_ch2 = addr == ADDR_W'(`CSR_CH2_OFF);
  wire hit_drv = addr == ADDR_W'(`CSR_DRV_OFF);
  wire hit_stat = addr == ADDR_W'(`CSR_STAT_OFF);

  // Write enables per register.
  wire [1:0] wr_chan = {wr_strobe && hit_ch2, wr_strobe && hit_ch1};
  wire wr_drv = wr_strobe && hit_drv;

  // Status word: undefined codes held in any register.
  wire [7:0] status_word = {5'h00, chop_bad, chan_bad};

  // Read multiplexer; an unmapped address reads as zero.
  wire [7:0] next_rdata = hit_ch1 ? chan_cfg[0] :
                          hit_ch2 ? chan_cfg[1] :
                          hit_drv ? drive_cfg :
                          hit_stat ? status_word :
                          8'h00;

  // The two channel registers, their decoders and their outputs.
  for (genvar i = 0; i < 2; i++) begin : g_chan
    // A write replaces the whole byte; reset clears every field.
    always_ff @(posedge clock) begin
      if (srst) begin
        // Reset brings every field back to its default of zero.
        chan_cfg[i] <= csr_chan_cfg_t'(`CSR_CH_RST);
      end else if (wr_chan[i]) begin
        // Any code is kept as written, even an undefined one; the decoder flags it.
        chan_cfg[i] <= csr_chan_cfg_t'(wdata);
      end
    end

    // Decoder turns the codes into gain factor and route.
    csr_chan_decode u_dec (
      .clock(clock),
      .srst(srst),
      .cfg(chan_cfg[i]),
      .gain_value(gain_arr[i]),
      .route(route_arr[i]),
      .cfg_bad(chan_bad[i])
    );
  end

  // Channel outputs are the registers and decoder flops directly.
  assign chan_one_cfg = chan_cfg[0];
  assign chan_two_cfg = chan_cfg[1];
  assign chan_one_gain = gain_arr[0];
  assign chan_two_gain = gain_arr[1];
  assign chan_one_route = route_arr[0];
  assign chan_two_route = route_arr[1];

  // Drive sense selection register.
  always_ff @(posedge clock) begin
    if (srst) begin
      // Reset leaves the buffer off and no input tapped.
      drive_cfg <= csr_drive_cfg_t'(`CSR_DRV_RST);
    end else if (wr_drv) begin
      // The whole byte is replaced, the reserved chop code included.
      drive_cfg <= csr_drive_cfg_t'(wdata);
    end
  end

  // Decoder for the chop divider and drive taps.
  csr_drive_decode u_drive (
    .clock(clock),
    .srst(srst),
    .cfg(drive_cfg),
    .chop_divide(chop_divide),
    .drive_taps(drive_taps),
    .chop_bad(chop_bad)
  );

  // Read data register: loaded on a read strobe, zero otherwise.
  always_ff @(posedge clock) begin
    if (srst) begin
      // Reset clears the read bus.
      rdata <= 8'h00;
    end else if (rd_strobe) begin
      // The addressed register stands for exactly one cycle.
      rdata <= next_rdata;
    end else begin
      // Idle cycles return zero so stale data never lingers on the bus.
      rdata <= 8'h00;
    end
  end

  // Checks on the register bank, all in the one clock domain.
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  // A write to channel one sets its power-down bit.
  a_pd_one_write: assert property (
    wr_strobe && hit_ch1 |=> chan_one_cfg.power_down == $past(wdata[`CSR_PD_BIT]))
    else $error("channel one power-down not stored");

  // A write to channel one sets its gain field.
  a_gain_one_write: assert property (
    wr_strobe && hit_ch1 |=>
      chan_one_cfg.gain_code == $past(wdata[`CSR_GAIN_HI:`CSR_GAIN_LO]))
    else $error("channel one gain not stored");

  // A write of input code 0000 to channel one routes input zero two cycles on.
  a_sel_one_route: assert property (
    wr_strobe && hit_ch1 && wdata[`CSR_SEL_HI:`CSR_SEL_LO] == 4'h0 |=>
      ##1 chan_one_route == `CSR_ROUTES'(1))
    else $error("electrode input not routed");

  // The reserved code is stored as written and routes nothing.
  a_sel_reserved: assert property (
    wr_strobe && hit_ch1 && wdata[`CSR_SEL_HI:`CSR_SEL_LO] == `CSR_SEL_RESERVED |=>
      chan_one_cfg.input_select == `CSR_SEL_RESERVED ##1 chan_one_route == '0)
    else $error("reserved input code mishandled");

  // A write to 05h lands in channel two and leaves channel one alone.
  a_ch2_write: assert property (
    wr_strobe && hit_ch2 |=> chan_two_cfg == $past(wdata) && $stable(chan_one_cfg))
    else $error("channel two write misplaced");

  // Channel two power-down follows its bit 7.
  a_pd_two_write: assert property (
    wr_strobe && hit_ch2 |=> chan_two_cfg.power_down == $past(wdata[`CSR_PD_BIT]))
    else $error("channel two power-down not stored");

  // Channel two gain code 110 gives factor twelve.
  a_gain_two_map: assert property (
    wr_strobe && hit_ch2 && wdata[`CSR_GAIN_HI:`CSR_GAIN_LO] == `CSR_GAIN_12 |=>
      ##1 chan_two_gain == 4'hc)
    else $error("channel two gain twelve not decoded");

  // Channel two third pair code routes bit nine.
  a_sel_two_pair: assert property (
    wr_strobe && hit_ch2 && wdata[`CSR_SEL_HI:`CSR_SEL_LO] == 4'h9 |=>
      ##1 chan_two_route[9])
    else $error("channel two third pair not routed");

  // A write to 06h lands in the drive sense register.
  a_drv_write: assert property (
    wr_strobe && hit_drv |=> drive_cfg == $past(drive_cfg_t_cast(wdata)))
    else $error("drive sense write misplaced");

  // With the buffer on, the taps mirror the four select bits.
  a_drv_taps: assert property (
    drive_cfg.drive_buffer_on |=> drive_taps == $past(drive_cfg[3:0]))
    else $error("drive taps do not follow selects");

  // Chop code 10 selects divide by two.
  a_chop_two: assert property (
    drive_cfg.chop_code == `CSR_CHOP_2 |=> chop_divide == 5'h02)
    else $error("chop divide by two not decoded");

  // A read of channel one returns the stored byte the next cycle only.
  a_read_back: assert property (
    rd_strobe && hit_ch1 |=> rdata == $past(chan_one_cfg))
    else $error("channel one read back wrong");

  // Reset leaves every field at zero.
  a_reset_zero: assert property (
    $past(srst) |-> chan_one_cfg == '0 && chan_two_cfg == '0 && drive_cfg == '0)
    else $error("register not zero after reset");

  // An unmapped read returns zero.
  a_unmapped_zero: assert property (
    rd_strobe && !(hit_ch1 || hit_ch2 || hit_drv || hit_stat) |=> rdata == 8'h00)
    else $error("unmapped read not zero");

  // An undefined channel one gain code shows in status bit zero.
  a_status_flag: assert property (
    chan_one_cfg.gain_code == 3'h7 ##1 rd_strobe && hit_stat |=> rdata[0])
    else $error("undefined gain code not reported");

  // The reserved chop code shows in status bit two.
  a_status_chop: assert property (
    drive_cfg.chop_code == `CSR_CHOP_RSV ##1 rd_strobe && hit_stat |=> rdata[2])
    else $error("reserved chop code not reported");

  // Channel one holds its value unless it is written.
  a_ch1_hold: assert property (
    !(wr_strobe && hit_ch1) |=> $stable(chan_one_cfg))
    else $error("channel one changed without a write");

  // Channel two holds its value unless it is written.
  a_ch2_hold: assert property (
    !(wr_strobe && hit_ch2) |=> $stable(chan_two_cfg))
    else $error("channel two changed without a write");

  // The drive sense register holds its value unless it is written.
  a_drv_hold: assert property (
    !(wr_strobe && hit_drv) |=> $stable(drive_cfg))
    else $error("drive sense changed without a write");

  // Without a read strobe the read bus returns zero.
  a_rdata_idle: assert property (
    !rd_strobe |=> rdata == 8'h00)
    else $error("read data present without a read");

  // A read of 05h returns channel two.
  a_read_two: assert property (
    rd_strobe && hit_ch2 |=> rdata == $past(chan_two_cfg))
    else $error("channel two read back wrong");

  // A read of 06h returns the drive sense register.
  a_read_drive: assert property (
    rd_strobe && hit_drv |=> rdata == $past(drive_cfg))
    else $error("drive sense read back wrong");

  // A reserved channel two select routes nothing.
  a_sel_two_reserved: assert property (
    wr_strobe && hit_ch2 && wdata[`CSR_SEL_HI:`CSR_SEL_LO] >= `CSR_SEL_RESERVED |=>
      ##1 chan_two_route == '0)
    else $error("channel two reserved code drove a route");

  // Channel one gain code 000 gives the default factor six.
  a_gain_one_six: assert property (
    wr_strobe && hit_ch1 && wdata[`CSR_GAIN_HI:`CSR_GAIN_LO] == `CSR_GAIN_6 |=>
      ##1 chan_one_gain == 4'h6)
    else $error("channel one gain six not decoded");

  // Chop code 00 selects divide by sixteen.
  a_chop_sixteen: assert property (
    drive_cfg.chop_code == `CSR_CHOP_16 |=> chop_divide == 5'h10)
    else $error("chop divide by sixteen not decoded");

  // Chop code 11 selects divide by four.
  a_chop_four: assert property (
    drive_cfg.chop_code == `CSR_CHOP_4 |=> chop_divide == 5'h04)
    else $error("chop divide by four not decoded");

  // Helper for the drive write check: byte viewed as the drive register.
  function automatic csr_drive_cfg_t drive_cfg_t_cast(input logic [7:0] b);
    return csr_drive_cfg_t'(b);
  endfunction

endmodule // channel_settings_regs

// ### verif/csr_host_model.sv
// Host controller model that drives the register port of the channel setting bank.
// Assumes the bank takes a strobe at a rising edge and answers a read one cycle later.
module csr_host_model (
  input wire logic clock,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr_strobe,
  output logic rd_strobe,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  `include "csr_defs.svh"

  // The port is idle from time zero.
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
  end

  // One write cycle; address and data stay put until the next request.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_strobe <= 1'b1;
    @(posedge clock);
    wr_strobe <= 1'b0;
  endtask

  // One read cycle; the data is taken at the edge that closes the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clock);
    rd_strobe <= 1'b0;
    @(posedge clock);
    d = rdata;
  endtask

  // The input is shorted before the channel is powered down; the gain code is sent as given.
  task automatic power_down(input logic [7:0] a, input logic [2:0] gain);
    wr(a, {1'b0, gain, `CSR_SEL_SHORTED});
    wr(a, {1'b1, gain, `CSR_SEL_SHORTED});
  endtask

  // Supply monitoring always goes with unity gain so the amplifier stays in range.
  task automatic supply_watch(input logic [7:0] a);
    wr(a, {1'b0, `CSR_GAIN_1, `CSR_SEL_SUPPLY});
  endtask
endmodule // csr_host_model

// ### verif/channel_settings_regs_tb.sv
// Self-checking bench for the channel setting register bank.
// Assumes the host model file and the design files are compiled first.
`include "csr_defs.svh"
`define CHK(name, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("ERROR %s expected %h seen %h", name, exp, got); \
    end \
  end
module channel_settings_regs_tb
  import csr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, srst, wr_strobe, rd_strobe;
  logic [7:0] addr, wdata, rdata;
  csr_chan_cfg_t chan_one_cfg, chan_two_cfg;
  csr_drive_cfg_t drive_cfg;
  logic [3:0] chan_one_gain, chan_two_gain, drive_taps;
  logic [`CSR_ROUTES-1:0] chan_one_route, chan_two_route;
  logic [4:0] chop_divide;
  int failures = 0;
  int comparisons = 0;
  // Gain factor expected for codes 000 to 110.
  logic [3:0] gain_tab [7] = '{4'h6, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hc};
  // Divider expected for chop codes 00 to 11; the reserved code gives zero.
  logic [4:0] chop_tab [4] = '{5'h10, 5'h00, 5'h02, 5'h04};

  channel_settings_regs #(.ADDR_W(8)) DUT (.clock(clock), .srst(srst), .addr(addr),
    .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
    .chan_one_cfg(chan_one_cfg), .chan_two_cfg(chan_two_cfg), .drive_cfg(drive_cfg),
    .chan_one_gain(chan_one_gain), .chan_two_gain(chan_two_gain),
    .chan_one_route(chan_one_route), .chan_two_route(chan_two_route),
    .chop_divide(chop_divide), .drive_taps(drive_taps));
  csr_host_model host (.clock(clock), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rdata(rdata));

  // The clock toggles every half period of 2.5 ns.
  initial clock = 1'b0;
  always #2.5 clock = ~clock;

  // Decoded outputs lag the stored setting by one cycle, so two edges are waited.
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // The watchdog cuts a hang short well beyond the few hundred cycles the tests need.
  initial begin
    #20000;
    failures++;
    close_out();
  end

  // Main sequence of tests.
  initial begin
    logic [7:0] d;
    logic [`CSR_ROUTES-1:0] r;
    srst = 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    // Every setting register reads zero after reset.
    host.rd(`CSR_CH1_OFF, d);
    `CHK("ch1 reset", 8'h00, d)
    host.rd(`CSR_CH2_OFF, d);
    `CHK("ch2 reset", 8'h00, d)
    host.rd(`CSR_DRV_OFF, d);
    `CHK("drive reset", 8'h00, d)
    `CHK("ch1 power", 1'b0, chan_one_cfg.power_down)
    `CHK("ch2 power", 1'b0, chan_two_cfg.power_down)
    $display("Test reset values done");
    // Fields land where the layout puts them and read back whole, back to back.
    host.wr(`CSR_CH1_OFF, 8'hd9);
    host.wr(`CSR_CH2_OFF, 8'ha7);
    host.wr(`CSR_DRV_OFF, 8'hbf);
    settle();
    `CHK("ch1 pd bit", 1'b1, chan_one_cfg.power_down)
    `CHK("ch1 gain field", 3'h5, chan_one_cfg.gain_code)
    `CHK("ch2 pd bit", 1'b1, chan_two_cfg.power_down)
    `CHK("ch2 select field", 4'h7, chan_two_cfg.input_select)
    `CHK("leadoff bit", 1'b1, drive_cfg.drive_leadoff_sense_en)
    `CHK("chop field", 2'h2, drive_cfg.chop_code)
    host.rd(`CSR_CH1_OFF, d);
    `CHK("ch1 readback", 8'hd9, d)
    host.rd(`CSR_CH2_OFF, d);
    `CHK("ch2 readback", 8'ha7, d)
    host.rd(`CSR_DRV_OFF, d);
    `CHK("drive readback", 8'hbf, d)
    $display("Test readback done");
    // Every defined gain code, 000 to 110, on both channels.
    for (int i = 0; i < 7; i++) begin
      host.wr(`CSR_CH1_OFF, {1'b0, i[2:0], 4'h0});
      host.wr(`CSR_CH2_OFF, {1'b0, i[2:0], 4'h1});
      settle();
      `CHK("ch1 gain", gain_tab[i], chan_one_gain)
      `CHK("ch2 gain", gain_tab[i], chan_two_gain)
    end
    $display("Test gain codes done");
    // Every input code up to the first reserved one, which gives no route.
    for (int i = 0; i < 11; i++) begin
      r = '0;
      if (i < `CSR_ROUTES) begin
        r[i] = 1'b1;
      end
      host.wr(`CSR_CH1_OFF, {4'h1, i[3:0]});
      host.wr(`CSR_CH2_OFF, {4'h1, i[3:0]});
      settle();
      `CHK("ch1 route", r, chan_one_route)
      `CHK("ch2 route", r, chan_two_route)
    end
    $display("Test input codes done");
    // Host sequences: short before power-down, unity gain with supply monitoring.
    host.power_down(`CSR_CH1_OFF, `CSR_GAIN_1);
    host.power_down(`CSR_CH2_OFF, `CSR_GAIN_2);
    settle();
    `CHK("ch1 powered down", 8'h91, chan_one_cfg)
    `CHK("ch2 powered down", 8'ha1, chan_two_cfg)
    host.supply_watch(`CSR_CH1_OFF);
    settle();
    `CHK("supply gain", 4'h1, chan_one_gain)
    `CHK("supply route", 10'h008, chan_one_route)
    $display("Test host sequences done");
    // Every chop code with the drive buffer on, then the buffer off.
    for (int i = 0; i < 4; i++) begin
      host.wr(`CSR_DRV_OFF, {i[1:0], 6'h25});
      settle();
      `CHK("chop divide", chop_tab[i], chop_divide)
      `CHK("taps buffer on", 4'h5, drive_taps)
    end
    host.wr(`CSR_DRV_OFF, 8'h05);
    settle();
    `CHK("taps buffer off", 4'h0, drive_taps)
    $display("Test drive sense done");
    // Unmapped and read-only places change nothing; an undefined code is flagged.
    host.wr(8'h20, 8'hff);
    host.wr(`CSR_STAT_OFF, 8'hff);
    host.rd(`CSR_CH2_OFF, d);
    `CHK("ch2 untouched", 8'ha1, d)
    host.rd(8'h20, d);
    `CHK("unmapped read", 8'h00, d)
    host.wr(`CSR_CH1_OFF, 8'h70);
    host.wr(`CSR_CH2_OFF, 8'h0a);
    host.wr(`CSR_DRV_OFF, 8'h40);
    host.rd(`CSR_STAT_OFF, d);
    `CHK("status flags", 8'h07, d)
    `CHK("undefined gain", 4'h0, chan_one_gain)
    $display("Test unmapped access done");
    // A reset in mid-run clears every setting again.
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    #1;
    `CHK("ch1 cleared", 8'h00, chan_one_cfg)
    `CHK("ch2 cleared", 8'h00, chan_two_cfg)
    `CHK("drive cleared", 8'h00, drive_cfg)
    settle();
    `CHK("default gain", 4'h6, chan_one_gain)
    `CHK("default route", 10'h001, chan_one_route)
    `CHK("default chop", 5'h10, chop_divide)
    $display("Test mid-run reset done");
    close_out();
  end
endmodule // channel_settings_regs_tb
